//--- brp_defines.vh
`ifndef BRP_DEFINES_VH
`define BRP_DEFINES_VH
// What this block does
// R1: Every packet starts with header characters s, n, p in order.
// R2: Header, type byte, address byte, data section, then two checksum bytes.
// R3: Type byte: payload bit7, multi bit6, batch length 5:2, concealed bit1, failed bit0.
// R4: No payload bit means no data bytes; checksum follows the address.
// R5: Payload plus multi: data is four bytes times the batch length.
// R6: Payload without multi: data is exactly four bytes.
// R7: A batch packet always carries a nonzero batch length.
// R8: Checksum is the 16-bit sum of all preceding bytes, header included.
// R9: Checksum goes out high byte first, then low byte.
// R10: Device uses the address as register, or batch start register.
// R11: Host reads with payload bit clear, multi bit for consecutive registers.
// R12: Read answer has payload set and copies multi and batch length.
// R13: Device stores written data, then sends a done reply.
// R14: Done reply has type byte zero and the written or start address.
// R15: Host triggers a command with a zero type byte and command address.
// R16: Command success gives done reply; failure sets the failed flag.
// R17: Commands with their own result packet send no done reply.
// R18: Concealed bit selects calibration space; host keeps it at zero. The host here sends req_conceal in that bit.
// R19: Host always keeps the failed flag clear in sent packets.
// R20: Device drops packets with bad checksum and sends no reply.

// ==========================================
// Header characters
`define BRP_HDR_S 8'h73
`define BRP_HDR_N 8'h6e
`define BRP_HDR_P 8'h70
// ==========================================
// Type byte fields
`define BRP_PT_PAYLOAD 7
`define BRP_PT_MULTI 6
`define BRP_PT_BLEN_HI 5
`define BRP_PT_BLEN_LO 2
`define BRP_PT_CONCEAL 1
`define BRP_PT_FAILED 0
`define BRP_REG_BYTES 3'h4
`define BRP_BYTE_W 8
`define BRP_SUM_W 16
`endif

//--- brp_skid.v
`include "brp_defines.vh"
// Two-entry buffer: stalls on the drain side lose no word
module brp_skid #(
    parameter W = 8
) (
    input wire clk_sys,
    input wire rstn,
    input wire [W-1:0] in_data,
    input wire in_valid,
    output wire in_ready,
    output wire [W-1:0] out_data,
    output wire out_valid,
    input wire out_ready
);
    reg [W-1:0] mem [0:1];
    reg rd_ptr;
    reg wr_ptr;
    reg [1:0] count;
    wire push = in_valid && in_ready;
    wire pop = out_valid && out_ready;

    assign in_ready = (count != 2'h2);
    assign out_valid = (count != 2'h0);
    assign out_data = mem[rd_ptr];

    // ==========================================
    // Storage and pointers
    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            rd_ptr <= 1'b0;
            wr_ptr <= 1'b0;
            count <= 2'h0;
        end else begin
            if (push)
                wr_ptr <= ~wr_ptr;
            if (pop)
                rd_ptr <= ~rd_ptr;
            if (push && !pop)
                count <= count + 2'h1;
            else if (pop && !push)
                count <= count - 2'h1;
        end
    end

    // Data array needs no reset
    always @(posedge clk_sys) begin
        if (push)
            mem[wr_ptr] <= in_data;
    end
endmodule

//--- brp_sum.v
`include "brp_defines.vh"
// Running 16-bit checksum over a byte stream
module brp_sum (
    input wire clk_sys,
    input wire rstn,
    input wire clear,
    input wire add,
    input wire [7:0] byte_in,
    output reg [15:0] sum
);
    // Clear with add restarts at this byte, so a header byte opens a fresh sum
    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn)
            sum <= 16'h0000;
        else if (clear)
            sum <= add ? {8'h00, byte_in} : 16'h0000; // [R8]
        else if (add)
            sum <= sum + {8'h00, byte_in}; // [R8]
    end
endmodule

//--- brp_host.v
`include "brp_defines.vh"
// Host end of the binary packet link: builds requests, parses replies
module brp_host #(
    parameter MAX_REGS = 16
) (
    input wire clk_sys,
    input wire rstn,
    // User request side
    input wire req_valid,
    output reg req_ready,
    input wire req_write,
    input wire req_multi,
    input wire [3:0] req_len,
    input wire [7:0] req_addr,
    input wire req_conceal,
    input wire [31:0] wr_word,
    output reg wr_word_take,
    // Serial byte link out
    output reg tx_data,
    output reg [7:0] tx_byte,
    input wire tx_ready,
    // Serial byte link in
    input wire [7:0] rx_byte,
    input wire rx_valid,
    // Reply side
    output reg rep_valid,
    output reg [7:0] rep_type,
    output reg [7:0] rep_addr,
    output reg [31:0] rep_word,
    output reg rep_word_valid,
    input wire rep_ready,
    output reg rep_done,
    output reg rep_failed,
    output reg bad_sum
);
    // ==========================================
    // Transmit sequencer
    localparam [2:0] T_IDLE = 3'h0;
    localparam [2:0] T_HDR = 3'h1;
    localparam [2:0] T_TYPE = 3'h2;
    localparam [2:0] T_ADDR = 3'h3;
    localparam [2:0] T_DATA = 3'h4;
    localparam [2:0] T_SUMH = 3'h5;
    localparam [2:0] T_SUML = 3'h6;

    // Data bytes implied by a type byte
    function [6:0] data_len;
        input [7:0] pt;
        begin
            if (!pt[`BRP_PT_PAYLOAD])
                data_len = 7'h00; // [R4]
            else if (pt[`BRP_PT_MULTI])
                data_len = {1'b0, pt[`BRP_PT_BLEN_HI:`BRP_PT_BLEN_LO], 2'b00}; // [R5]
            else
                data_len = {4'h0, `BRP_REG_BYTES}; // [R6]
        end
    endfunction

    reg [2:0] t_state;
    reg [1:0] hdr_idx;
    reg [7:0] t_pt;
    reg [7:0] t_addr;
    reg [6:0] t_cnt;
    reg [31:0] t_word;
    reg [7:0] t_cur;
    reg t_go;
    wire [15:0] t_sum;
    wire [3:0] eff_len = (req_multi && req_len == 4'h0) ? 4'h1 : req_len; // [R7]
    wire [3:0] t_blen = req_multi ? eff_len : 4'h0; // [R11]

    // Current transmit byte
    always @* begin
        case (t_state)
            T_HDR: t_cur = (hdr_idx == 2'h0) ? `BRP_HDR_S : (hdr_idx == 2'h1) ? `BRP_HDR_N : `BRP_HDR_P; // [R1]
            T_TYPE: t_cur = t_pt;
            T_ADDR: t_cur = t_addr;
            T_DATA: t_cur = t_word[31:24];
            T_SUMH: t_cur = t_sum[15:8]; // [R9]
            T_SUML: t_cur = t_sum[7:0];
            default: t_cur = 8'h00;
        endcase
    end

    // Load the output byte only when it is empty or being taken, so a stall drops nothing
    wire t_fire = t_go && (!tx_data || tx_ready);
    wire t_add = t_fire && (t_state == T_HDR || t_state == T_TYPE || t_state == T_ADDR || t_state == T_DATA);

    brp_sum u_tsum (
        .clk_sys(clk_sys),
        .rstn(rstn),
        .clear(t_state == T_IDLE),
        .add(t_add),
        .byte_in(t_cur),
        .sum(t_sum)
    );

    // Transmit state machine; outputs held in flops
    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            t_state <= T_IDLE;
            hdr_idx <= 2'h0;
            t_pt <= 8'h00;
            t_addr <= 8'h00;
            t_cnt <= 7'h00;
            t_word <= 32'h0000_0000;
            t_go <= 1'b0;
            req_ready <= 1'b0;
            wr_word_take <= 1'b0;
            tx_data <= 1'b0;
            tx_byte <= 8'h00;
        end else begin
            wr_word_take <= 1'b0;
            req_ready <= (t_state == T_IDLE) && !req_ready;
            case (t_state)
                T_IDLE: begin
                    t_go <= 1'b0;
                    if (req_valid && req_ready) begin
                        // Failed flag kept clear; concealed only on explicit request
                        t_pt <= {req_write, req_multi, t_blen, req_conceal, 1'b0}; // [R3] [R15] [R18] [R19]
                        t_addr <= req_addr;
                        t_cnt <= data_len({req_write, req_multi, eff_len, 2'b00});
                        t_word <= wr_word;
                        wr_word_take <= req_write;
                        hdr_idx <= 2'h0;
                        t_state <= T_HDR;
                        t_go <= 1'b1;
                        req_ready <= 1'b0;
                    end
                end
                default: begin
                    if (t_fire) begin
                        case (t_state)
                            T_HDR: begin
                                hdr_idx <= hdr_idx + 2'h1;
                                if (hdr_idx == 2'h2)
                                    t_state <= T_TYPE;
                            end
                            T_TYPE: t_state <= T_ADDR; // [R2]
                            T_ADDR: t_state <= (t_cnt == 7'h00) ? T_SUMH : T_DATA;
                            T_DATA: begin
                                t_cnt <= t_cnt - 7'h01;
                                if (t_cnt[1:0] == 2'b01 && t_cnt != 7'h01) begin
                                    t_word <= wr_word; // Next register, MSB first
                                    wr_word_take <= 1'b1;
                                end else begin
                                    t_word <= {t_word[23:0], 8'h00};
                                end
                                if (t_cnt == 7'h01)
                                    t_state <= T_SUMH;
                            end
                            T_SUMH: t_state <= T_SUML;
                            default: begin
                                t_state <= T_IDLE;
                                t_go <= 1'b0;
                            end
                        endcase
                    end
                end
            endcase
            // Output byte stands until the link takes it
            if (t_fire) begin
                tx_data <= 1'b1;
                tx_byte <= t_cur;
            end else if (tx_ready) begin
                tx_data <= 1'b0;
            end
        end
    end

    // ==========================================
    // Receive parser
    localparam [2:0] R_S = 3'h0;
    localparam [2:0] R_N = 3'h1;
    localparam [2:0] R_P = 3'h2;
    localparam [2:0] R_TYPE = 3'h3;
    localparam [2:0] R_ADDR = 3'h4;
    localparam [2:0] R_DATA = 3'h5;
    localparam [2:0] R_SUMH = 3'h6;
    localparam [2:0] R_SUML = 3'h7;

    reg [2:0] r_state;
    reg [7:0] r_pt;
    reg [7:0] r_addr;
    reg [6:0] r_cnt;
    reg [31:0] r_shift;
    reg [7:0] r_sumh;
    reg [31:0] words [0:MAX_REGS-1];
    reg [4:0] w_cnt;
    reg [4:0] w_out;
    reg emit;
    wire [15:0] r_sum;
    wire r_clear = rx_valid && r_state == R_S;
    wire r_add = rx_valid && r_state <= R_DATA;

    brp_sum u_rsum (
        .clk_sys(clk_sys),
        .rstn(rstn),
        .clear(r_clear), // Any byte while hunting restarts the sum
        .add(r_add),
        .byte_in(rx_byte),
        .sum(r_sum)
    );

    // Reply words leave through the two-entry buffer
    wire b_in_ready;
    wire b_out_valid;
    wire [31:0] b_out_data;
    wire b_pop = b_out_valid && (!rep_word_valid || rep_ready);

    brp_skid #(.W(32)) u_buf (
        .clk_sys(clk_sys),
        .rstn(rstn),
        .in_data(words[w_out[3:0]]),
        .in_valid(emit),
        .in_ready(b_in_ready),
        .out_data(b_out_data),
        .out_valid(b_out_valid),
        .out_ready(!rep_word_valid || rep_ready)
    );

    // Word output stage
    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            rep_word_valid <= 1'b0;
            rep_word <= 32'h0000_0000;
        end else if (b_pop) begin
            rep_word_valid <= 1'b1;
            rep_word <= b_out_data;
        end else if (rep_ready) begin
            rep_word_valid <= 1'b0;
        end
    end

    // Parser; bytes are parsed as they arrive, even while earlier words still drain
    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            r_state <= R_S;
            r_pt <= 8'h00;
            r_addr <= 8'h00;
            r_cnt <= 7'h00;
            r_shift <= 32'h0000_0000;
            r_sumh <= 8'h00;
            w_cnt <= 5'h00;
            w_out <= 5'h00;
            emit <= 1'b0;
            rep_valid <= 1'b0;
            rep_type <= 8'h00;
            rep_addr <= 8'h00;
            rep_done <= 1'b0;
            rep_failed <= 1'b0;
            bad_sum <= 1'b0;
        end else begin
            rep_valid <= 1'b0;
            rep_done <= 1'b0;
            rep_failed <= 1'b0;
            bad_sum <= 1'b0;
            if (emit && b_in_ready) begin
                w_out <= w_out + 5'h01;
                if (w_out + 5'h01 == w_cnt)
                    emit <= 1'b0;
            end
            if (rx_valid) begin
                case (r_state)
                    R_S: r_state <= (rx_byte == `BRP_HDR_S) ? R_N : R_S; // [R1]
                    R_N: r_state <= (rx_byte == `BRP_HDR_N) ? R_P : R_S;
                    R_P: r_state <= (rx_byte == `BRP_HDR_P) ? R_TYPE : R_S;
                    R_TYPE: begin
                        r_pt <= rx_byte;
                        r_cnt <= data_len(rx_byte);
                        r_state <= R_ADDR;
                    end
                    R_ADDR: begin
                        r_addr <= rx_byte;
                        w_cnt <= 5'h00;
                        r_state <= (r_cnt == 7'h00) ? R_SUMH : R_DATA;
                    end
                    R_DATA: begin
                        r_shift <= {r_shift[23:0], rx_byte};
                        r_cnt <= r_cnt - 7'h01;
                        if (r_cnt[1:0] == 2'b01) begin
                            words[w_cnt[3:0]] <= {r_shift[23:0], rx_byte};
                            w_cnt <= w_cnt + 5'h01;
                        end
                        if (r_cnt == 7'h01)
                            r_state <= R_SUMH;
                    end
                    R_SUMH: begin
                        r_sumh <= rx_byte;
                        r_state <= R_SUML;
                    end
                    default: begin
                        r_state <= R_S;
                        if ({r_sumh, rx_byte} == r_sum) begin // [R8] [R9]
                            rep_valid <= 1'b1;
                            rep_type <= r_pt;
                            rep_addr <= r_addr;
                            // Zero type is done; failed flag alone is failure
                            rep_done <= (r_pt == 8'h00); // [R14] [R16]
                            rep_failed <= r_pt[`BRP_PT_FAILED]; // [R16]
                            w_out <= 5'h00;
                            emit <= (w_cnt != 5'h00); // [R12] [R17]
                        end else begin
                            bad_sum <= 1'b1;
                        end
                    end
                endcase
            end
        end
    end
endmodule

//--- brp_properties.sv
`include "brp_defines.vh"
// ==========================================
// Link and reply checks
module brp_properties (
    input wire clk_sys,
    input wire rstn,
    input wire req_valid,
    input wire req_ready,
    input wire tx_data,
    input wire [7:0] tx_byte,
    input wire tx_ready,
    input wire rep_valid,
    input wire [7:0] rep_type,
    input wire [31:0] rep_word,
    input wire rep_word_valid,
    input wire rep_ready,
    input wire rep_done,
    input wire rep_failed,
    input wire bad_sum
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [6:0] idx;
    logic [15:0] sum;
    logic [7:0] pt;
    logic [7:0] lo;
    wire take = tx_data && tx_ready;
    wire [6:0] plen = 7'd7 + (!pt[7] ? 7'd0 : pt[6] ? {1'b0, pt[5:2], 2'b00} : 7'd4);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rstn);
    // Byte index and sum, restarted per request so a lost byte shifts everything
    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            idx <= 7'd0;
            sum <= 16'h0000;
            pt <= 8'h00;
            lo <= 8'h00;
        end else if (req_valid && req_ready) begin
            idx <= 7'd0;
            sum <= 16'h0000;
        end else if (take) begin
            idx <= idx + 7'd1;
            sum <= sum + {8'h00, tx_byte};
            if (idx == 7'd3) pt <= tx_byte;
            if (idx == plen - 7'd2) lo <= sum[7:0];
        end
    end
    sequence s_at(int i);
        take && idx == i;
    endsequence
    sequence s_stall;
        rep_word_valid && !rep_ready;
    endsequence
    property p_hdr_s; s_at(0) |-> tx_byte == `BRP_HDR_S; endproperty
    a_hdr_s: assert property (p_hdr_s) else $error("first byte wrong");
    property p_hdr_np; s_at(1) or s_at(2) |-> tx_byte == (idx == 7'd1 ? `BRP_HDR_N : `BRP_HDR_P); endproperty
    a_hdr_np: assert property (p_hdr_np) else $error("header byte wrong");
    property p_flag; s_at(3) |-> tx_byte[`BRP_PT_FAILED] == 1'b0; endproperty
    a_flag: assert property (p_flag) else $error("failed flag sent");
    property p_sum_hi; take && idx > 7'd4 && idx == plen - 7'd2 |-> tx_byte == sum[15:8]; endproperty
    a_sum_hi: assert property (p_sum_hi) else $error("checksum high wrong");
    property p_sum_lo; take && idx > 7'd5 && idx == plen - 7'd1 |-> tx_byte == lo; endproperty
    a_sum_lo: assert property (p_sum_lo) else $error("checksum low wrong");
    property p_done; rep_done |-> rep_valid && rep_type == 8'h00 && !rep_failed; endproperty
    a_done: assert property (p_done) else $error("done reply wrong");
    property p_fail; rep_failed |-> rep_valid && rep_type[`BRP_PT_FAILED]; endproperty
    a_fail: assert property (p_fail) else $error("fail reply wrong");
    property p_bad; bad_sum |-> !rep_valid ##1 !rep_valid; endproperty
    a_bad: assert property (p_bad) else $error("bad packet reported");
    property p_hold; s_stall |=> rep_word_valid && $stable(rep_word); endproperty
    a_hold: assert property (p_hold) else $error("word lost in stall");
endmodule

//--- brp_dev_model.sv
`include "brp_defines.vh"
// ==========================================
// Device on the far side of the link
module brp_dev_model #(
    parameter logic [31:0] FW_WORD = 32'h3141_5926 // Arbitrary
) (
    input wire clk_sys,
    input wire rstn,
    input wire tx_data,
    input wire [7:0] tx_byte,
    output logic tx_ready,
    output logic [7:0] rx_byte,
    output logic rx_valid,
    input wire slow,
    input wire corrupt
);
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [7:0] HDR [3] = '{`BRP_HDR_S, `BRP_HDR_N, `BRP_HDR_P};
    logic [31:0] regs [0:511];
    logic [7:0] rb [0:79];
    logic [7:0] q [$];
    int n = 0;
    int cyc = 0;
    // Reply build; corrupt spoils the sum so the host must drop it
    task automatic reply(logic [7:0] pt, logic [7:0] a, int nw);
        logic [7:0] b [$];
        logic [15:0] s;
        b = '{`BRP_HDR_S, `BRP_HDR_N, `BRP_HDR_P, pt, a};
        for (int j = 0; j < 4 * nw; j++) b.push_back(regs[{pt[1], a + 8'(j / 4)}][31 - 8 * (j % 4) -: 8]);
        s = 16'h0000;
        foreach (b[j]) s = s + b[j];
        if (corrupt) s = ~s;
        b.push_back(s[15:8]);
        b.push_back(s[7:0]);
        q = {q, b};
    endtask
    task automatic take_pkt();
        logic [15:0] s;
        logic [7:0] pt;
        logic [7:0] a;
        s = 16'h0000;
        pt = rb[3];
        a = rb[4];
        for (int i = 0; i < n - 2; i++) s = s + rb[i];
        if (s != {rb[n - 2], rb[n - 1]}) return;
        if (pt[7]) begin
            for (int i = 0; i < n - 7; i++)
                regs[{pt[1], a + 8'(i / 4)}][31 - 8 * (i % 4) -: 8] = rb[5 + i];
            reply(8'h00, a, 0);
        end else if (a == 8'haa) reply(8'h80, a, 1);
        else if (a == 8'hab) reply(8'h01, a, 0);
        else if (a >= 8'ha0) reply(8'h00, a, 0);
        else reply({1'b1, pt[6:0]}, a, pt[6] ? int'(pt[5:2]) : 1);
    endtask
    // Stall every other cycle when slow
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        tx_ready <= !slow || cyc[0];
    end
    // Collect a host packet; a wrong header byte restarts the search
    always @(posedge clk_sys) begin
        if (!rstn) n = 0;
        else if (tx_data && tx_ready) begin
            rb[n] = tx_byte;
            n = n + 1;
            if (n <= 3 && tx_byte != HDR[n - 1]) n = 0;
            else if (n > 4 && n == 7 + (rb[3][7] ? (rb[3][6] ? 4 * rb[3][5:2] : 4) : 0)) begin
                take_pkt();
                n = 0;
            end
        end
    end
    // Send replies; idle line inverts its byte each cycle, so the last byte returns every second idle cycle
    initial begin
        tx_ready = 1'b0;
        rx_valid = 1'b0;
        rx_byte = 8'h00;
        foreach (regs[i]) regs[i] = 32'(i);
        regs[9'h0aa] = FW_WORD;
        forever begin
            @(posedge clk_sys);
            if (q.size() > 0 && !(slow && cyc[1])) begin
                rx_valid <= 1'b1;
                rx_byte <= q.pop_front();
            end else begin
                rx_valid <= 1'b0;
                rx_byte <= ~rx_byte;
            end
        end
    end
endmodule

//--- tb_top.sv
`include "brp_defines.vh"
// ==========================================
// Host engine bench
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    `define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin errors++; \
        $display("mismatch %s exp %h got %h", nm, e, g); end end
    localparam logic [31:0] FW_WORD = 32'h3141_5926; // Arbitrary
    logic clk_sys = 0, rstn = 0, req_valid = 0, req_write = 0, req_multi = 0, req_conceal = 0;
    logic rep_ready = 1, slow = 0, corrupt = 0;
    logic [3:0] req_len = 0;
    logic [7:0] req_addr = 0;
    logic [31:0] wr_word = 0;
    wire req_ready, wr_word_take, tx_data, tx_ready, rx_valid;
    wire rep_valid, rep_word_valid, rep_done, rep_failed, bad_sum;
    wire [7:0] tx_byte, rx_byte, rep_type, rep_addr;
    wire [31:0] rep_word;
    int errors = 0, cmp_count = 0, cycles = 0, nrep = 0, nbad = 0, wi = 0, n0, n1;
    logic [7:0] txq [$];
    logic [31:0] wq [$], rq [$];
    logic [17:0] last = 0;
    brp_host dut_u (.clk_sys, .rstn, .req_valid, .req_ready, .req_write, .req_multi, .req_len, .req_addr,
        .req_conceal, .wr_word, .wr_word_take, .tx_data, .tx_byte, .tx_ready, .rx_byte, .rx_valid, .rep_valid,
        .rep_type, .rep_addr, .rep_word, .rep_word_valid, .rep_ready, .rep_done, .rep_failed, .bad_sum);
    brp_dev_model #(.FW_WORD(FW_WORD)) dev_u (.clk_sys, .rstn, .tx_data, .tx_byte, .tx_ready, .rx_byte, .rx_valid,
        .slow, .corrupt);
    initial forever #10 clk_sys = ~clk_sys;
    // Record link and reply traffic; feed write words; cut a hang short
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (tx_data && tx_ready) txq.push_back(tx_byte);
        if (rep_valid) nrep++;
        if (rep_valid) last = {rep_done, rep_failed, rep_type, rep_addr};
        if (bad_sum) nbad++;
        if (rep_word_valid && rep_ready) rq.push_back(rep_word);
        if (wr_word_take) wi++;
        if (wr_word_take) wr_word <= (wi < wq.size()) ? wq[wi] : 32'h0000_0000;
        if (cycles == 40000) begin
            errors++;
            summarize();
        end
    end
    task automatic summarize();
        if (errors == 0 && cmp_count > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    // One request, then the outgoing bytes against a packet built here
    task automatic send(logic w, logic m, logic [3:0] len, logic [7:0] a);
        logic [7:0] e [$];
        logic [15:0] s;
        int k;
        n0 = nrep + nbad;
        e = '{`BRP_HDR_S, `BRP_HDR_N, `BRP_HDR_P, {w, m, (m && len == 4'h0) ? 4'h1 : len, req_conceal, 1'b0}, a};
        if (w) foreach (wq[i]) for (int j = 3; j >= 0; j--) e.push_back(wq[i][8 * j +: 8]);
        s = 16'h0000;
        foreach (e[i]) s = s + e[i];
        e.push_back(s[15:8]);
        e.push_back(s[7:0]);
        @(posedge clk_sys);
        txq = {};
        rq = {};
        wi = 0;
        req_write <= w;
        req_multi <= m;
        req_len <= len;
        req_addr <= a;
        req_valid <= 1'b1;
        wr_word <= (wq.size() > 0) ? wq[0] : 32'h0000_0000;
        do @(posedge clk_sys); while (!req_ready);
        req_valid <= 1'b0;
        for (k = 0; k < 600 && nrep + nbad == n0; k++) @(posedge clk_sys);
        repeat (4) @(posedge clk_sys);
        `CHK("tx_len", e.size(), txq.size())
        foreach (e[i]) `CHK("tx_byte", e[i], txq[i])
    endtask
    task automatic wait_words(int n);
        for (int k = 0; k < 300 && rq.size() < n; k++) @(posedge clk_sys);
    endtask
    task automatic t_batch();
        wq = '{32'h1122_3344};
        send(1'b1, 1'b0, 4'h0, 8'h10);
        `CHK("wr_rep", 18'h2_0010, last)
        wq = '{32'h0a0b_0c0d, 32'h1a1b_1c1d, 32'h2a2b_2c2d};
        send(1'b1, 1'b1, 4'h3, 8'h20);
        `CHK("bw_rep", 18'h2_0020, last)
        send(1'b0, 1'b1, 4'h3, 8'h20);
        wait_words(3);
        `CHK("br_rep", 18'h0_cc20, last)
        `CHK("br_words", {wq[0], wq[1], wq[2]}, {rq[0], rq[1], rq[2]})
    endtask
    task automatic t_stall();
        slow <= 1'b1;
        rep_ready <= 1'b0;
        send(1'b0, 1'b0, 4'h0, 8'h21);
        repeat (6) @(posedge clk_sys);
        `CHK("st_hold", {1'b1, 32'h1a1b_1c1d}, {rep_word_valid, rep_word})
        rep_ready <= 1'b1;
        wait_words(1);
        `CHK("st_rep", 18'h0_8021, last)
        `CHK("st_word", 32'h1a1b_1c1d, rq[0])
        slow <= 1'b0;
    endtask
    task automatic t_cmd();
        logic [7:0] a [3] = '{8'ha0, 8'hab, 8'haa};
        logic [17:0] x [3] = '{18'h2_00a0, 18'h1_01ab, 18'h0_80aa};
        for (int i = 0; i < 3; i++) begin
            n1 = nrep;
            send(1'b0, 1'b0, 4'h0, a[i]);
            repeat (40) @(posedge clk_sys);
            `CHK("cmd_rep", x[i], last)
            `CHK("cmd_count", n1 + 1, nrep)
        end
        `CHK("fw_word", FW_WORD, rq[0])
    endtask
    task automatic t_bad();
        n1 = nbad;
        corrupt <= 1'b1;
        send(1'b0, 1'b0, 4'h0, 8'h10);
        corrupt <= 1'b0;
        `CHK("bad_seen", {n0, n1 + 1}, {nrep, nbad})
        send(1'b0, 1'b1, 4'h0, 8'h22);
        wait_words(1);
        `CHK("z_rep", 18'h0_c422, last)
        `CHK("z_word", 32'h2a2b_2c2d, rq[0])
    endtask
    // Concealed read must reach the other register space
    task automatic t_hidden();
        req_conceal <= 1'b1;
        @(posedge clk_sys);
        send(1'b0, 1'b0, 4'h0, 8'h10);
        req_conceal <= 1'b0;
        wait_words(1);
        `CHK("hid_rep", 18'h0_8210, last)
        `CHK("hid_word", 32'h0000_0110, rq[0])
    endtask
    // Main sequence
    initial begin
        repeat (2) @(posedge clk_sys);
        rstn <= 1'b1;
        repeat (2) @(posedge clk_sys);
        t_batch();
        t_stall();
        t_cmd();
        t_bad();
        t_hidden();
        summarize();
    end
endmodule
bind brp_host brp_properties chk_u (.clk_sys, .rstn, .req_valid, .req_ready, .tx_data, .tx_byte, .tx_ready,
    .rep_valid, .rep_type, .rep_word, .rep_word_valid, .rep_ready, .rep_done, .rep_failed, .bad_sum);
